//--- hdl/adc_seq_pkg.sv
// Constants, types and register map of the conversion sequencer
// Contract
// RL1: Prescaler counts while enable set, held in reset while enable low.
// RL2: Prescaler divides any processor clock above 100 kHz by selected ratio.
// RL3: Software keeps converter clock within 50 to 200 kHz for full resolution.
// RL4: Conversion starts on next converter clock rising edge after start write.
// RL5: Normal conversions take exactly 13 converter clock cycles.
// RL6: First conversion after enabling takes 25 converter clock cycles.
// RL7: Sample-and-hold at 1.5 cycles normal, 13.5 cycles first conversion.
// RL8: Completion writes result, sets done flag, clears start in single mode.
// RL9: Free-running restarts immediately after completion, start bit stays high.
// RL10: Selection buffered; working copy tracks until start, then locked.
// RL11: Tracking resumes in last converter cycle before completion.
// RL12: Software waits one converter cycle after start before changing selection.
// RL13: Software changes selection only in the three safe windows.
// RL14: Free-run change after completion affects only later conversions.
// RL15: Sleep entry in qualifying state starts a conversion once halted.
// RL16: Sleep-started conversion still raises completion request after early wake.
// RL17: Other sleep modes never disable the converter automatically.
// RL18: Over-reference input saturates at maximum code, never wraps.
// RL19: Software discards first result after reference switch.
// RL20: Start bit reads one during conversion, zero after; writing zero ignored.
// RL21: Done flag cleared by vector taken or by writing one.
// RL22: Low byte read blocks result updates until high byte read.
// RL23: Prescale select is three bits of power-of-two division.
// RL24: Clearing enable aborts conversion; next conversion is extended again.
package adc_seq_pkg;
   localparam logic [11:0] ctrl_status_offset = 12'h000;
   localparam logic [11:0] select_offset = 12'h004;
   localparam logic [11:0] result_low_offset = 12'h008;
   localparam logic [11:0] result_high_offset = 12'h00C;
   localparam logic [11:0] sleep_ctrl_offset = 12'h010;
   localparam int enable_pos = 7;
   localparam int start_pos = 6;
   localparam int free_run_pos = 5;
   localparam int done_pos = 4;
   localparam int irq_en_pos = 3;
   localparam int high_speed_pos = 8;
   localparam logic [7:0] ctrl_reset = 8'h00;
   localparam logic [7:0] select_reset = 8'h00;
   localparam logic [9:0] max_code = 10'h3FF;
   localparam logic [4:0] normal_cycles = 5'd13;
   localparam logic [4:0] first_cycles = 5'd25;
   localparam logic [4:0] normal_sample_cycle = 5'd1;
   localparam logic [4:0] first_sample_cycle = 5'd13;
   localparam logic [1:0] sleep_idle = 2'd1;
   localparam logic [1:0] sleep_noise = 2'd2;
   typedef enum logic [1:0] {st_idle, st_convert} conv_state_t;
   typedef struct packed {
      logic [1:0] reference_bits;
      logic [3:0] channel_bits;
   } selection_t;
endpackage : adc_seq_pkg

//--- hdl/adc_conversion_sequencer.sv
// Conversion sequencer with APB register slave
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module adc_conversion_sequencer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [9:0] core_result,
   input wire logic core_over_ref,
   input wire logic cpu_halted,
   input wire logic [1:0] sleep_mode,
   input wire logic vector_taken,
   output logic [5:0] working_select,
   output logic core_enable,
   output logic sample_hold,
   output logic conv_running,
   output logic converter_clk_tick,
   output logic conversion_irq
);
   // ****************************************
   // Register state
   // ****************************************
   logic converter_enable;
   logic start_conversion;
   logic free_run_select;
   logic conversion_done_flag;
   logic conversion_done_irq_en;
   logic high_speed_conv_mode;
   logic [2:0] prescale_select;
   logic left_adjust;
   adc_seq_pkg::selection_t temp_select;
   logic [9:0] result;
   logic result_locked;
   logic [6:0] prescale_count;
   logic tick;
   logic half_tick;
   adc_seq_pkg::conv_state_t state;
   logic [4:0] cycle;
   logic first_pending;
   logic extended;
   logic sleep_armed;
   logic irq_pending;
   logic [15:0] result_view;

   wire access = psel && penable;
   wire wr = access && pwrite;
   wire rd = access && !pwrite;
   wire [4:0] last_cycle = extended ? adc_seq_pkg::first_cycles : adc_seq_pkg::normal_cycles;
   wire [4:0] sample_cycle = extended ? adc_seq_pkg::first_sample_cycle :
      adc_seq_pkg::normal_sample_cycle;
   wire completing = (state == adc_seq_pkg::st_convert) && tick && (cycle == last_cycle - 5'd1);
   wire sleep_start = converter_enable && !start_conversion && !free_run_select &&
      conversion_done_irq_en && cpu_halted && sleep_armed &&
      (sleep_mode == adc_seq_pkg::sleep_idle || sleep_mode == adc_seq_pkg::sleep_noise);

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction : hit

   function automatic logic mapped(input logic [11:0] a);
      mapped = hit(a, adc_seq_pkg::ctrl_status_offset) || hit(a, adc_seq_pkg::select_offset) ||
         hit(a, adc_seq_pkg::result_low_offset) || hit(a, adc_seq_pkg::result_high_offset);
   endfunction : mapped

   wire ctrl_write = wr && hit(paddr, adc_seq_pkg::ctrl_status_offset);
   wire next_enable = ctrl_write ? pwdata[adc_seq_pkg::enable_pos] : converter_enable;

   // ****************************************
   // Prescaler
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale_count <= 7'h00;
      end else if (!converter_enable) begin
         prescale_count <= 7'h00; // see RL1
      end else begin
         prescale_count <= prescale_count + 7'h01; // see RL1
      end
   end

   // Tick is the converter clock rising edge, division 2 to 128
   always_comb begin
      case (prescale_select) // see RL23
         3'd0, 3'd1: tick = converter_enable && (prescale_count[0] == 1'b1); // see RL2
         3'd2: tick = converter_enable && (prescale_count[1:0] == 2'b11);
         3'd3: tick = converter_enable && (prescale_count[2:0] == 3'b111);
         3'd4: tick = converter_enable && (prescale_count[3:0] == 4'hF);
         3'd5: tick = converter_enable && (prescale_count[4:0] == 5'h1F);
         3'd6: tick = converter_enable && (prescale_count[5:0] == 6'h3F);
         default: tick = converter_enable && (prescale_count == 7'h7F);
      endcase
   end

   // Half tick is the converter clock falling edge
   always_comb begin
      case (prescale_select)
         3'd0, 3'd1: half_tick = converter_enable && (prescale_count[0] == 1'b0);
         3'd2: half_tick = converter_enable && (prescale_count[1:0] == 2'b01);
         3'd3: half_tick = converter_enable && (prescale_count[2:0] == 3'b011);
         3'd4: half_tick = converter_enable && (prescale_count[3:0] == 4'h7);
         3'd5: half_tick = converter_enable && (prescale_count[4:0] == 5'h0F);
         3'd6: half_tick = converter_enable && (prescale_count[5:0] == 6'h1F);
         default: half_tick = converter_enable && (prescale_count == 7'h3F);
      endcase
   end

   // ****************************************
   // Sequencer
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= adc_seq_pkg::st_idle;
         cycle <= 5'h00;
         extended <= 1'b0;
      end else if (!converter_enable) begin
         state <= adc_seq_pkg::st_idle; // see RL24
         cycle <= 5'h00;
      end else begin
         case (state)
            adc_seq_pkg::st_idle: begin
               if (start_conversion && tick) begin
                  state <= adc_seq_pkg::st_convert; // see RL4
                  cycle <= 5'h00;
                  extended <= first_pending; // see RL6
               end
            end
            adc_seq_pkg::st_convert: begin
               if (completing) begin
                  cycle <= 5'h00;
                  extended <= 1'b0; // see RL5
                  if (!free_run_select) begin
                     state <= adc_seq_pkg::st_idle;
                  end // else restart at once, see RL9
               end else if (tick) begin
                  cycle <= cycle + 5'd1;
               end
            end
            default: state <= adc_seq_pkg::st_idle;
         endcase
      end
   end

   // First conversion marker, rearmed by disable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_pending <= 1'b1;
      end else if (!converter_enable) begin
         first_pending <= 1'b1; // see RL24
      end else if (state == adc_seq_pkg::st_idle && start_conversion && tick) begin
         first_pending <= 1'b0;
      end
   end

   // Working selection tracks except while locked
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         working_select <= adc_seq_pkg::select_reset[5:0];
      end else if (state == adc_seq_pkg::st_idle && !(start_conversion && tick)) begin
         working_select <= temp_select; // see RL10
      end else if (state == adc_seq_pkg::st_convert && cycle == last_cycle - 5'd1) begin
         working_select <= temp_select; // see RL11, see RL14
      end
   end

   // Sample instant half a cycle after the counted edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_hold <= 1'b0;
      end else begin
         sample_hold <= (state == adc_seq_pkg::st_convert) && half_tick &&
            (cycle == sample_cycle); // see RL7
      end
   end

   // ****************************************
   // Control and status register
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         converter_enable <= 1'b0;
      end else begin
         converter_enable <= next_enable; // see RL17
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         free_run_select <= 1'b0;
         conversion_done_irq_en <= 1'b0;
         prescale_select <= 3'h0;
         high_speed_conv_mode <= 1'b0;
      end else if (ctrl_write) begin
         free_run_select <= pwdata[adc_seq_pkg::free_run_pos];
         conversion_done_irq_en <= pwdata[adc_seq_pkg::irq_en_pos];
         prescale_select <= pwdata[2:0];
         high_speed_conv_mode <= pwdata[adc_seq_pkg::high_speed_pos];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_conversion <= 1'b0;
      end else if (!next_enable) begin
         start_conversion <= 1'b0; // see RL24
      end else if (completing && !free_run_select) begin
         start_conversion <= 1'b0; // see RL8
      end else if (ctrl_write && pwdata[adc_seq_pkg::start_pos]) begin
         start_conversion <= 1'b1; // see RL20
      end else if (sleep_start) begin
         start_conversion <= 1'b1; // see RL15
      end
   end

   // Halt edge detector for sleep start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_armed <= 1'b0;
      end else begin
         sleep_armed <= !cpu_halted;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conversion_done_flag <= 1'b0;
      end else if (completing) begin
         conversion_done_flag <= 1'b1; // see RL8
      end else if (vector_taken || (wr && hit(paddr, adc_seq_pkg::ctrl_status_offset) &&
                   pwdata[adc_seq_pkg::done_pos])) begin
         conversion_done_flag <= 1'b0; // see RL21
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_pending <= 1'b0;
      end else begin
         irq_pending <= conversion_done_flag && conversion_done_irq_en; // see RL16
      end
   end

   // ****************************************
   // Selection and result registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         temp_select <= adc_seq_pkg::select_reset[5:0];
         left_adjust <= 1'b0;
      end else if (wr && hit(paddr, adc_seq_pkg::select_offset)) begin
         temp_select <= {pwdata[7:6], pwdata[3:0]}; // see RL14
         left_adjust <= pwdata[5];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_locked <= 1'b0;
      end else if (rd && hit(paddr, adc_seq_pkg::result_high_offset)) begin
         result_locked <= 1'b0;
      end else if (rd && hit(paddr, adc_seq_pkg::result_low_offset)) begin
         result_locked <= 1'b1; // see RL22
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result <= 10'h000;
      end else if (completing && !result_locked) begin
         result <= core_over_ref ? adc_seq_pkg::max_code : core_result; // see RL18
      end
   end

   always_comb begin
      result_view = left_adjust ? {result, 6'h00} : {6'h00, result};
   end

   // ****************************************
   // APB slave
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped(paddr);
         prdata <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               adc_seq_pkg::ctrl_status_offset: prdata <= {23'h0, high_speed_conv_mode,
                  converter_enable, start_conversion, free_run_select, conversion_done_flag,
                  conversion_done_irq_en, prescale_select};
               adc_seq_pkg::select_offset: prdata <= {24'h00_0000, temp_select.reference_bits,
                  left_adjust, 1'b0, temp_select.channel_bits};
               adc_seq_pkg::result_low_offset: prdata <= {24'h00_0000, result_view[7:0]};
               adc_seq_pkg::result_high_offset: prdata <= {24'h00_0000, result_view[15:8]};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ****************************************
   // Core outputs
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_enable <= 1'b0;
      end else begin
         core_enable <= converter_enable;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_running <= 1'b0;
      end else begin
         conv_running <= (state == adc_seq_pkg::st_convert);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         converter_clk_tick <= 1'b0;
      end else begin
         converter_clk_tick <= tick;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conversion_irq <= 1'b0;
      end else begin
         conversion_irq <= irq_pending;
      end
   end
endmodule : adc_conversion_sequencer

//--- tb/adc_conversion_sequencer_assertions.sv
// Port checker for the conversion sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic vector_taken,
   input wire logic [5:0] working_select,
   input wire logic core_enable,
   input wire logic sample_hold,
   input wire logic conv_running,
   input wire logic converter_clk_tick,
   input wire logic conversion_irq
);
   // ****
   // Tick gap between sample instants
   // ****
   logic [4:0] gap;
   logic seen;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap <= 5'h0;
         seen <= 1'b0;
      end else if (!conv_running) begin
         gap <= 5'h0;
         seen <= 1'b0;
      end else if (sample_hold) begin
         gap <= 5'h0;
         seen <= 1'b1;
      end else if (converter_clk_tick && gap != 5'h1F) begin
         gap <= gap + 5'h1;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_start;
      $rose(conv_running);
   endsequence
   sequence s_locked;
      $stable(working_select) [*8];
   endsequence
   property p_lock; s_start |=> s_locked; endproperty
   property p_tick_off; !core_enable && !$past(core_enable) |-> !converter_clk_tick; endproperty
   property p_tick_gap; converter_clk_tick |=> !converter_clk_tick; endproperty
   property p_abort; $fell(core_enable) |-> ##[0:2] !conv_running; endproperty
   property p_sample; sample_hold |-> conv_running; endproperty
   property p_irq_clear; vector_taken && !conv_running |-> ##[1:3] !conversion_irq; endproperty
   property p_ready; psel && penable |-> pready; endproperty
   property p_err; pslverr |-> psel && penable; endproperty
   property p_spacing; sample_hold && seen |-> gap + 5'(converter_clk_tick) == 5'hD; endproperty
   a_lock: assert property (p_lock) else $error("selection moved in conversion");
   a_tick_off: assert property (p_tick_off) else $error("tick while disabled");
   a_tick_gap: assert property (p_tick_gap) else $error("tick too fast");
   a_abort: assert property (p_abort) else $error("no abort on disable");
   a_sample: assert property (p_sample) else $error("sample outside conversion");
   a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared");
   a_ready: assert property (p_ready) else $error("no ready in access");
   a_err: assert property (p_err) else $error("error outside access");
   a_spacing: assert property (p_spacing) else $error("sample spacing wrong");
endmodule : adc_conversion_sequencer_assertions
bind adc_conversion_sequencer adc_conversion_sequencer_assertions u_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .vector_taken(vector_taken), .working_select(working_select), .core_enable(core_enable),
   .sample_hold(sample_hold), .conv_running(conv_running),
   .converter_clk_tick(converter_clk_tick), .conversion_irq(conversion_irq));

//--- tb/analog_core_model.sv
// Behavioural analog core facing the sequencer
`timescale 1ns/1ps
module analog_core_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic core_enable,
   input wire logic sample_hold,
   input wire logic [9:0] level,
   input wire logic over,
   output logic [9:0] core_result,
   output logic core_over_ref
);
   logic [9:0] held;
   logic held_over;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held <= 10'h000;
         held_over <= 1'b0;
      end else if (sample_hold) begin
         held <= level;
         held_over <= over;
      end
   end
   // Powered-down core shows the inverted held code
   assign core_result = core_enable ? held : ~held;
   assign core_over_ref = core_enable & held_over;
endmodule : analog_core_model

//--- tb/test_adc_conversion_sequencer.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module test_adc_conversion_sequencer;
   localparam logic [11:0] a_ctl = adc_seq_pkg::ctrl_status_offset;
   localparam logic [11:0] a_sel = adc_seq_pkg::select_offset;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic cpu_halted = 1'b0;
   logic [1:0] sleep_mode = 2'h0;
   logic vector_taken = 1'b0;
   logic [9:0] level = 10'h000;
   logic over = 1'b0;
   logic [31:0] prdata, rd;
   logic [9:0] core_result, v;
   logic [5:0] working_select, s;
   logic pready, pslverr, core_over_ref, core_enable, sample_hold, conv_running;
   logic converter_clk_tick, conversion_irq, err;
   int n_errors = 0;
   int n_checks = 0;
   int ticks = 0;
   int i;
   adc_conversion_sequencer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .core_result(core_result),
      .core_over_ref(core_over_ref), .cpu_halted(cpu_halted), .sleep_mode(sleep_mode),
      .vector_taken(vector_taken), .working_select(working_select),
      .core_enable(core_enable), .sample_hold(sample_hold), .conv_running(conv_running),
      .converter_clk_tick(converter_clk_tick), .conversion_irq(conversion_irq));
   analog_core_model u_core (.pclk(pclk), .presetn(presetn), .core_enable(core_enable),
      .sample_hold(sample_hold), .level(level), .over(over), .core_result(core_result),
      .core_over_ref(core_over_ref));
   always #10 pclk = ~pclk;
   always @(posedge pclk) begin
      if (conv_running === 1'b1 && converter_clk_tick === 1'b1) ticks <= ticks + 1;
   end
   // ****
   // Tasks
   // ****
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k == 50) n_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_conv();
      int k;
      k = 0;
      while (conv_running !== 1'b1 && k < 400) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 400) n_errors++;
      while (conv_running !== 1'b0 && k < 8000) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 8000) n_errors++;
   endtask : wait_conv
   task automatic conv(input logic [7:0] c, input int n);
      ticks = 0;
      apb(1'b1, a_ctl, {24'h00_0000, c});
      wait_conv();
      chk(ticks, n);
   endtask : conv
   task automatic rres(input logic [9:0] e);
      apb(1'b0, adc_seq_pkg::result_low_offset, 32'h0);
      chk(rd, {24'h00_0000, e[7:0]});
      apb(1'b0, adc_seq_pkg::result_high_offset, 32'h0);
      chk(rd, {30'h0, e[9:8]});
   endtask : rres
   function automatic logic [9:0] code(input logic [9:0] l, input logic o);
      return o ? adc_seq_pkg::max_code : l;
   endfunction : code
   task automatic end_of_test();
      if (n_errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test
   // ****
   // Scenarios
   // ****
   initial begin
      i = $urandom(28224);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, a_ctl, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      level <= 10'h2A5;
      apb(1'b1, a_sel, 32'h45);
      conv(8'hC9, 25);
      chk(working_select, 32'h15);
      rres(10'h2A5);
      apb(1'b0, a_ctl, 32'h0);
      chk(rd & 32'h50, 32'h10);
      chk(conversion_irq, 32'h1);
      vector_taken <= 1'b1;
      @(posedge pclk);
      vector_taken <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(conversion_irq, 32'h0);
      over <= 1'b1;
      ticks = 0;
      apb(1'b1, a_ctl, 32'hC9);
      apb(1'b1, a_ctl, 32'h89);
      apb(1'b0, a_ctl, 32'h0);
      chk(rd[6], 32'h1);
      wait_conv();
      chk(ticks, 13);
      rres(code(10'h155, 1'b1));
      apb(1'b1, a_ctl, 32'h99);
      apb(1'b0, a_ctl, 32'h0);
      chk(rd[4], 32'h0);
      over <= 1'b0;
      level <= 10'h1A1;
      conv(8'hC9, 13);
      apb(1'b0, adc_seq_pkg::result_low_offset, 32'h0);
      level <= 10'h0F0;
      conv(8'hD9, 13);
      apb(1'b0, a_ctl, 32'h0);
      chk(rd[4], 32'h1);
      apb(1'b0, adc_seq_pkg::result_high_offset, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, a_sel, 32'h20);
      apb(1'b0, adc_seq_pkg::result_high_offset, 32'h0);
      chk(rd, 32'h68);
      for (i = 0; i < 4; i++) begin
         s = 6'($urandom);
         v = 10'($urandom);
         level <= v;
         apb(1'b1, a_sel, {24'h00_0000, s[5:4], 2'b00, s[3:0]});
         conv(8'hC8 | 8'($urandom % 4), 13);
         chk(working_select, {26'h0, s});
         rres(code(v, 1'b0));
      end
      apb(1'b1, a_ctl, 32'hE8);
      repeat (120) @(posedge pclk);
      apb(1'b0, a_ctl, 32'h0);
      chk(rd[6], 32'h1);
      apb(1'b1, a_ctl, 32'h88);
      wait_conv();
      apb(1'b0, a_ctl, 32'h0);
      chk(rd[6], 32'h0);
      apb(1'b1, a_ctl, 32'hC8);
      repeat (6) @(posedge pclk);
      apb(1'b1, a_ctl, 32'h0);
      repeat (3) @(posedge pclk);
      chk({conv_running, core_enable}, 32'h0);
      conv(8'hC8, 25);
      sleep_mode <= 2'h3;
      cpu_halted <= 1'b1;
      repeat (20) @(posedge pclk);
      chk({conv_running, core_enable}, 32'h1);
      cpu_halted <= 1'b0;
      for (i = 1; i < 3; i++) begin
         apb(1'b1, a_ctl, 32'h98);
         ticks = 0;
         sleep_mode <= 2'(i);
         cpu_halted <= 1'b1;
         repeat (10) @(posedge pclk);
         cpu_halted <= 1'b0;
         wait_conv();
         chk(ticks, 13);
         repeat (3) @(posedge pclk);
         chk(conversion_irq, 32'h1);
      end
      end_of_test();
   end
   initial begin
      repeat (40000) @(posedge pclk);
      n_errors++;
      end_of_test();
   end
endmodule : test_adc_conversion_sequencer
